// *** pkg/adc_seq_defines.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_RESULT 8'h08
`define ADDR_INT_STAT 8'h0c
`define ADDR_INT_MASK 8'h10

`define CTRL_MODE_LSB 0
`define CTRL_RES_LSB 2
`define CTRL_ROUTE_BIT 7
`define CTRL_START_BIT 8
`define CTRL_STOP_BIT 9

`define MODE_SINGLE 2'h0
`define MODE_MULTI 2'h1
`define MODE_CONT 2'h2
`define MODE_TURBO 2'h3

`define RES_RESET 5'h10
`define RES_TURBO_MIN 5'h11
`define PRIME_LAST 2'h3

`define INT_EOC_BIT 0
`define INT_IGN_BIT 1
`define INT_W 2

`define CONV_CYCLES_DEF 16
`define RESULT_W 20

`endif

// *** pkg/adc_seq_pkg.sv ***
// types shared by the conversion sequencer
`default_nettype none
package adc_seq_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RESET = 3'b010,
    ST_RUN = 3'b100
  } seq_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic route_dma;
    logic [4:0] res;
    logic [1:0] mode;
  } ctrl_t;

endpackage : adc_seq_pkg
`default_nettype wire

// *** core/conv_timer.sv ***
// paces one modulator conversion, pulses at its end
`default_nettype none
module conv_timer #(
  parameter int CYCLES = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control and event
  input wire logic run,
  output logic conv_end
);

  localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic end_d;

  always_comb begin
    cnt_d = '0;
    end_d = 1'b0;
    if (run) begin
      if (cnt_q == LAST) begin
        end_d = 1'b1;
      end else begin
        cnt_d = cnt_q + CW'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      conv_end <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      conv_end <= end_d;
    end
  end

endmodule : conv_timer
`default_nettype wire

// *** core/adc_conv_seq.sv ***
// conversion sequencer: modes, start trigger, end-of-conversion flag
`default_nettype none
`include "adc_seq_defines.svh"

// Function
// - turbo mode at 8 to 16 bits runs exactly like multi-sample mode.
// - turbo mode at 17 to 20 bits resets the decimator only once per run.
// - a rise on the start input begins a conversion.
// - continuous mode works with the start input left unconnected.
// - the done output goes high at the end of every conversion result.
// - the done output can feed either the interrupt or the DMA request.
// - every mode starts from the control start bit or the start input.
// - done sets a status bit and stays high until CPU or DMA reads.
// - single mode runs four conversions, reports the fourth, then idles.
// - multi mode re-primes between samples and restarts on its own.
module adc_conv_seq
  import adc_seq_pkg::*;
#(
  parameter int CONV_CYCLES = `CONV_CYCLES_DEF
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire adc_seq_pkg::bus_req_t bus,
  output logic [31:0] rdata,
  // trigger and decimator
  input wire logic soc_pin,
  input wire logic [`RESULT_W-1:0] dec_data,
  output logic dec_rst,
  // done and requests
  input wire logic dma_ack,
  output logic eoc,
  output logic dma_req,
  output logic irq
);
  import adc_seq_pkg::*;

  seq_state_t state_q, state_d;
  ctrl_t ctrl_q, ctrl_d;
  logic [1:0] cnt_q, cnt_d;
  logic [`RESULT_W-1:0] result_q, result_d;
  logic [`INT_W-1:0] ist_q, ist_d, imask_q, imask_d;
  logic [31:0] rdata_d;
  logic soc_s1_q, soc_s2_q, soc_s3_q;
  logic eoc_d, dma_d, irq_d, drst_d;
  logic conv_end, sw_start, sw_stop, pin_start, start_req;
  logic result_ld, eoc_clr, rearm, keep_run;

  conv_timer #(.CYCLES(CONV_CYCLES)) u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(state_q == ST_RUN),
    .conv_end(conv_end)
  );

  // start input synchroniser
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      soc_s1_q <= 1'b0;
      soc_s2_q <= 1'b0;
      soc_s3_q <= 1'b0;
    end else begin
      soc_s1_q <= soc_pin;
      soc_s2_q <= soc_s1_q;
      soc_s3_q <= soc_s2_q;
    end
  end

  always_comb begin
    sw_start = bus.wr && (bus.addr == `ADDR_CTRL) &&
               bus.wdata[`CTRL_START_BIT];
    sw_stop = bus.wr && (bus.addr == `ADDR_CTRL) &&
              bus.wdata[`CTRL_STOP_BIT];
    pin_start = soc_s2_q && !soc_s3_q;
    start_req = sw_start || pin_start;
    result_ld = (state_q == ST_RUN) && conv_end && (cnt_q == `PRIME_LAST);
    eoc_clr = dma_ack || (bus.rd && (bus.addr == `ADDR_RESULT));
    // re-prime between samples: multi, and turbo at low resolution
    rearm = (ctrl_q.mode == `MODE_MULTI) ||
            ((ctrl_q.mode == `MODE_TURBO) &&
             (ctrl_q.res < `RES_TURBO_MIN));
    // no reset between samples once primed
    keep_run = (ctrl_q.mode == `MODE_CONT) ||
               ((ctrl_q.mode == `MODE_TURBO) &&
                (ctrl_q.res >= `RES_TURBO_MIN));
  end

  // sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    drst_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (start_req && !sw_stop) begin
          state_d = ST_RESET;
          drst_d = 1'b1;
        end
      end
      ST_RESET: begin
        cnt_d = 2'h0;
        state_d = ST_RUN;
      end
      ST_RUN: begin
        if (sw_stop) begin
          state_d = ST_IDLE;
        end else if (conv_end) begin
          if (cnt_q != `PRIME_LAST) begin
            cnt_d = cnt_q + 2'h1;
          end else if (rearm) begin
            state_d = ST_RESET;
            drst_d = 1'b1;
          end else if (!keep_run) begin
            state_d = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d = 2'h0;
      end
    endcase
  end

  // registers, flags and outputs
  always_comb begin
    ctrl_d = ctrl_q;
    imask_d = imask_q;
    result_d = result_q;
    ist_d = ist_q;
    rdata_d = 32'h0;
    if (bus.wr) begin
      case (bus.addr)
        `ADDR_CTRL: begin
          ctrl_d.mode = bus.wdata[`CTRL_MODE_LSB +: 2];
          ctrl_d.res = bus.wdata[`CTRL_RES_LSB +: 5];
          ctrl_d.route_dma = bus.wdata[`CTRL_ROUTE_BIT];
        end
        `ADDR_INT_STAT: ist_d = ist_q & ~bus.wdata[`INT_W-1:0];
        `ADDR_INT_MASK: imask_d = bus.wdata[`INT_W-1:0];
        default: ;
      endcase
    end
    if (result_ld) begin
      result_d = dec_data;
    end
    eoc_d = eoc && !eoc_clr;
    if (result_ld) begin
      eoc_d = 1'b1;
    end
    // set wins over a write-one clear
    if (result_ld && !ctrl_q.route_dma) begin
      ist_d[`INT_EOC_BIT] = 1'b1;
    end
    if (start_req && (state_q != ST_IDLE)) begin
      ist_d[`INT_IGN_BIT] = 1'b1;
    end
    dma_d = eoc_d && ctrl_d.route_dma;
    irq_d = |(ist_d & imask_d);
    if (bus.rd) begin
      case (bus.addr)
        `ADDR_CTRL: rdata_d = {24'h0, ctrl_q.route_dma, ctrl_q.res,
                               ctrl_q.mode};
        `ADDR_STATUS: rdata_d = {26'h0, cnt_q, eoc, state_q};
        `ADDR_RESULT: rdata_d = {12'h0, result_q};
        `ADDR_INT_STAT: rdata_d = {30'h0, ist_q};
        `ADDR_INT_MASK: rdata_d = {30'h0, imask_q};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 2'h0;
      ctrl_q <= '{route_dma: 1'b0, res: `RES_RESET, mode: `MODE_SINGLE};
      imask_q <= '0;
      ist_q <= '0;
      result_q <= '0;
      rdata <= 32'h0;
      dec_rst <= 1'b0;
      eoc <= 1'b0;
      dma_req <= 1'b0;
      irq <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ctrl_q <= ctrl_d;
      imask_q <= imask_d;
      ist_q <= ist_d;
      result_q <= result_d;
      rdata <= rdata_d;
      dec_rst <= drst_d;
      eoc <= eoc_d;
      dma_req <= dma_d;
      irq <= irq_d;
    end
  end

  start_taken_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == ST_IDLE && start_req && !sw_stop) |=>
      dec_rst && state_q == ST_RESET ##1 state_q == ST_RUN)
    else $error("start not taken from idle");

  start_ignored_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == ST_RUN && start_req && !conv_end && !sw_stop) |=>
      state_q == ST_RUN && $stable(cnt_q) && ist_q[`INT_IGN_BIT])
    else $error("start disturbed a running sequence");

  eoc_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    result_ld |=> eoc && result_q == $past(dec_data))
    else $error("done not raised with result");

  eoc_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (eoc && !eoc_clr) |=> eoc)
    else $error("done dropped before read");

  single_four_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result_ld && ctrl_q.mode == `MODE_SINGLE && !sw_stop) |=>
      state_q == ST_IDLE && !dec_rst)
    else $error("single mode did not return to idle");

  multi_rearm_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result_ld && rearm && !sw_stop) |=>
      dec_rst ##1 (state_q == ST_RUN && cnt_q == 2'h0))
    else $error("multi mode did not re-prime");

  turbo_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result_ld && ctrl_q.mode == `MODE_TURBO &&
     ctrl_q.res >= `RES_TURBO_MIN && !sw_stop) |=>
      (state_q == ST_RUN && !dec_rst) ##1 !dec_rst)
    else $error("turbo high resolution reset between samples");

  turbo_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result_ld && ctrl_q.mode == `MODE_TURBO &&
     ctrl_q.res < `RES_TURBO_MIN && !sw_stop) |=> dec_rst)
    else $error("turbo low resolution not like multi");

  cont_run_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result_ld && ctrl_q.mode == `MODE_CONT && !sw_stop) |=>
      state_q == ST_RUN && cnt_q == `PRIME_LAST)
    else $error("continuous mode stopped");

  dma_route_a: assert property (@(posedge mclk) disable iff (!rst_n)
    dma_req == (eoc && ctrl_q.route_dma))
    else $error("dma request not following done");

endmodule : adc_conv_seq
`default_nettype wire

// *** test/far_side_model.sv ***
// far side: decimator count, trigger clock and dma acknowledge
`default_nettype none
module far_side_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // from the sequencer
  input wire logic dec_rst,
  input wire logic dma_req,
  // scenario control
  input wire logic trig_en,
  input wire logic ack_en,
  // to the sequencer
  output logic soc_pin,
  output logic dma_ack,
  output logic [19:0] dec_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] div_q;
  // result counts decimator resets, so re-priming shows in the data
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 5'h0;
      soc_pin <= 1'b0;
      dma_ack <= 1'b0;
      dec_data <= 20'h0;
    end else begin
      div_q <= trig_en ? div_q + 5'h1 : 5'h0;
      soc_pin <= trig_en & div_q[4];
      dma_ack <= ack_en & dma_req & ~dma_ack;
      if (dec_rst) begin
        dec_data <= dec_data + 20'h1;
      end
    end
  end
endmodule : far_side_model
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the conversion sequencer
`default_nettype none
`include "adc_seq_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import adc_seq_pkg::*;
  localparam int N = 2;
  localparam logic [31:0] MODES [4] = '{32'h41, 32'h43, 32'h47, 32'h42};
  localparam logic [31:0] STEPS [4] = '{32'h1, 32'h1, 32'h0, 32'h0};
  logic mclk, rst_n, soc_pin, dec_rst, dma_ack, eoc, dma_req, irq;
  logic trig_en, ack_en;
  logic [19:0] dec_data;
  logic [31:0] rdata, r0, r1;
  bus_req_t bus;
  int fail_count, num_checks, n;

  adc_conv_seq #(.CONV_CYCLES(N)) u_adc_conv_seq (
    .mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .soc_pin(soc_pin), .dec_data(dec_data), .dec_rst(dec_rst),
    .dma_ack(dma_ack), .eoc(eoc), .dma_req(dma_req), .irq(irq));
  far_side_model u_far_side_model (
    .mclk(mclk), .rst_n(rst_n), .dec_rst(dec_rst), .dma_req(dma_req),
    .trig_en(trig_en), .ack_en(ack_en), .soc_pin(soc_pin),
    .dma_ack(dma_ack), .dec_data(dec_data));

  task automatic check(input string w, input logic [31:0] s,
                       input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", w, e, s);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd
  task automatic rc(input string w, input logic [7:0] a,
                    input logic [31:0] m, input logic [31:0] e);
    rd(a, r0);
    check(w, r0 & m, e);
  endtask : rc
  task automatic wait_eoc;
    n = 0;
    while (eoc !== 1'b1 && n < 200) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 200) check("eoc wait", 32'h0, 32'h1);
  endtask : wait_eoc
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // watchdog at about fifty times the expected run
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end

  initial begin
    bus = '0;
    trig_en = 1'b0;
    ack_en = 1'b0;
    rst_n = 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    rc("ctrl reset", `ADDR_CTRL, 32'hffffffff, 32'h40);
    rc("status reset", `ADDR_STATUS, 32'hf, 32'h1);
    rc("unmapped", 8'h20, 32'hffffffff, 32'h0);
    $display("test reset done");
    wr(`ADDR_INT_MASK, 32'h3);
    wr(`ADDR_CTRL, 32'h140);
    wait_eoc();
    check("single latency", n, 4 * N + 2);
    check("irq on done", irq, 1'b1);
    rc("status done", `ADDR_STATUS, 32'hf, 32'h9);
    rc("result single", `ADDR_RESULT, 32'hfffff, 32'h1);
    check("eoc after read", eoc, 1'b0);
    rc("int event", `ADDR_INT_STAT, 32'h3, 32'h1);
    wr(`ADDR_INT_STAT, 32'h1);
    @(posedge mclk);
    #1;
    check("irq cleared", irq, 1'b0);
    repeat (20) @(posedge mclk);
    #1;
    check("single standby", eoc, 1'b0);
    $display("test single done");
    wr(`ADDR_CTRL, 32'h140);
    wr(`ADDR_CTRL, 32'h140);
    wr(`ADDR_CTRL, 32'h140);
    wait_eoc();
    check("busy latency", n, 4 * N);
    rc("busy result", `ADDR_RESULT, 32'hfffff, 32'h2);
    rc("busy ignored", `ADDR_INT_STAT, 32'h3, 32'h3);
    wr(`ADDR_INT_STAT, 32'h3);
    $display("test busy start done");
    trig_en <= 1'b1;
    wait_eoc();
    trig_en <= 1'b0;
    rc("pin result", `ADDR_RESULT, 32'hfffff, 32'h3);
    wr(`ADDR_INT_STAT, 32'h3);
    $display("test start pin done");
    ack_en <= 1'b1;
    wr(`ADDR_CTRL, 32'h1c0);
    wait_eoc();
    check("dma request", dma_req, 1'b1);
    repeat (3) @(posedge mclk);
    #1;
    check("dma clears eoc", eoc, 1'b0);
    rc("dma no irq", `ADDR_INT_STAT, 32'h1, 32'h0);
    ack_en <= 1'b0;
    $display("test dma done");
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_CTRL, MODES[i] | 32'h100);
      wait_eoc();
      rd(`ADDR_RESULT, r1);
      wait_eoc();
      rd(`ADDR_RESULT, r0);
      check("mode step", r0 - r1, STEPS[i]);
      wr(`ADDR_CTRL, MODES[i] | 32'h200);
      repeat (4) @(posedge mclk);
      rd(`ADDR_RESULT, r1);
      rc("stop idle", `ADDR_STATUS, 32'h7, 32'h1);
    end
    $display("test modes done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
